// File: hw/lvm_monitor.sv
`timescale 1ns/1ps
module lvm_monitor (
  // Clock and reset.
  input  wire logic                         CORE_CLK,
  input  wire logic                         RESET,
  // AXI4-Lite write address channel.
  input  wire logic [lvm_pkg::ADDR_W-1:0]   AWADDR,
  input  wire logic [2:0]                   AWPROT,
  input  wire logic                         AWVALID,
  output logic                              AWREADY,
  // AXI4-Lite write data channel.
  input  wire logic [lvm_pkg::DATA_W-1:0]   WDATA,
  input  wire logic [3:0]                   WSTRB,
  input  wire logic                         WVALID,
  output logic                              WREADY,
  // AXI4-Lite write response channel.
  output logic      [1:0]                   BRESP,
  output logic                              BVALID,
  input  wire logic                         BREADY,
  // AXI4-Lite read address channel.
  input  wire logic [lvm_pkg::ADDR_W-1:0]   ARADDR,
  input  wire logic [2:0]                   ARPROT,
  input  wire logic                         ARVALID,
  output logic                              ARREADY,
  // AXI4-Lite read data channel.
  output logic      [lvm_pkg::DATA_W-1:0]   RDATA,
  output logic      [1:0]                   RRESP,
  output logic                              RVALID,
  input  wire logic                         RREADY,
  // Analog comparator side.
  input  wire logic                         SUPPLY_BELOW,
  output logic                              MONITOR_POWER_ON,
  output logic      [2:0]                   THRESHOLD_SELECT,
  output logic      [lvm_pkg::MV_W-1:0]     THRESHOLD_VOLTAGE_MV,
  // CPU interrupt controller side.
  output logic                              MONITOR_IRQ_REQ,
  output logic                              MONITOR_IRQ_PRIORITY,
  // Bus-side event interrupt.
  output logic                              EVENT_IRQ
);
  import lvm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser and event detection.

  logic       below_sync;
  logic       power_on_q;
  logic       power_on_d;
  logic [2:0] thr_sel_q;
  logic [2:0] thr_sel_d;
  logic       below_q;
  logic       below_d;
  logic       irq_flag_q;
  logic       irq_flag_d;
  logic       irq_enable_q;
  logic       irq_enable_d;
  logic       irq_prio_q;
  logic       irq_prio_d;
  logic       monitor_event;
  logic       fall_event;
  logic       rise_event;
  logic [1:0] warm_q;
  logic [1:0] warm_d;
  logic       sample_ok;

  lvm_sync2 u_sync (
    .clk      (CORE_CLK),
    .rst      (RESET),
    .async_in (SUPPLY_BELOW),
    .sync_out (below_sync)
  );

  // A change of a valid comparator sample is an event in either direction.
  assign monitor_event = sample_ok && (below_sync != below_q);
  assign fall_event    = monitor_event && below_sync;
  assign rise_event    = monitor_event && !below_sync;

  // The flag follows valid comparator samples and rests at 0 while the monitor is off
  // or still settling after power-on.
  assign below_d = sample_ok ? below_sync : 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator settling after power-on.

  // For two edges after power-on the synchroniser still carries samples that were
  // taken while the comparator was unpowered, and those mean nothing. The shift
  // register fills with ones behind the power bit, so the flag and the events only
  // look at the comparator once both stages hold powered samples.
  assign warm_d    = power_on_q ? {warm_q[0], 1'b1} : 2'h0;
  assign sample_ok = power_on_q && warm_q[1];

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      warm_q <= 2'h0;
    end else begin
      warm_q <= warm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel.

  logic                aw_ready_q;
  logic                aw_ready_d;
  logic                w_ready_q;
  logic                w_ready_d;
  logic                aw_have_q;
  logic                aw_have_d;
  logic                w_have_q;
  logic                w_have_d;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic [ADDR_W-1:0]   aw_addr_d;
  logic [7:0]          w_byte_q;
  logic [7:0]          w_byte_d;
  logic                w_lane_q;
  logic                w_lane_d;
  logic                bvalid_q;
  logic                bvalid_d;
  logic [1:0]          bresp_q;
  logic [1:0]          bresp_d;
  logic                aw_take;
  logic                w_take;
  logic                wr_fire;
  logic                wr_lane;
  logic                hit_w_ie2;
  logic                hit_w_ctl;
  logic                hit_w_ip2;
  logic                hit_w_evs;
  logic                hit_w_evm;
  logic                hit_w_any;

  // A write is applied once address and data are both held and the last response
  // has been taken, so one write at most is ever under way.
  assign aw_take  = AWVALID && aw_ready_q;
  assign w_take   = WVALID && w_ready_q;
  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane  = wr_fire && w_lane_q;

  assign aw_have_d = (aw_have_q || aw_take) && !wr_fire;
  assign w_have_d  = (w_have_q || w_take) && !wr_fire;
  assign aw_addr_d = aw_take ? AWADDR : aw_addr_q;
  assign w_byte_d  = w_take ? WDATA[7:0] : w_byte_q;
  assign w_lane_d  = w_take ? WSTRB[0] : w_lane_q;
  assign bvalid_d  = wr_fire || (bvalid_q && !BREADY);
  assign bresp_d   = wr_fire ? (hit_w_any ? RESP_OKAY : RESP_SLVERR) : bresp_q;
  assign aw_ready_d = !aw_have_d && !bvalid_d;
  assign w_ready_d  = !w_have_d && !bvalid_d;

  assign hit_w_ie2 = reg_hit(aw_addr_q, IDX_IRQ_ENABLE_TWO);
  assign hit_w_ctl = reg_hit(aw_addr_q, IDX_MONITOR_CONTROL);
  assign hit_w_ip2 = reg_hit(aw_addr_q, IDX_IRQ_PRIORITY_TWO);
  assign hit_w_evs = reg_hit(aw_addr_q, IDX_EVENT_STATUS);
  assign hit_w_evm = reg_hit(aw_addr_q, IDX_EVENT_MASK);
  assign hit_w_any = hit_w_ie2 || hit_w_ctl || hit_w_ip2 || hit_w_evs || hit_w_evm;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      aw_ready_q <= 1'b0;
      w_ready_q  <= 1'b0;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      aw_addr_q  <= '0;
      w_byte_q   <= 8'h00;
      w_lane_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
    end else begin
      aw_ready_q <= aw_ready_d;
      w_ready_q  <= w_ready_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      aw_addr_q  <= aw_addr_d;
      w_byte_q   <= w_byte_d;
      w_lane_q   <= w_lane_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, enable and priority registers.

  logic wr_ctl;
  logic wr_ie2;
  logic wr_ip2;
  logic sw_clear_irq;

  assign wr_ctl = wr_lane && hit_w_ctl;
  assign wr_ie2 = wr_lane && hit_w_ie2;
  assign wr_ip2 = wr_lane && hit_w_ip2;

  assign power_on_d = wr_ctl ? w_byte_q[CTL_POWER_BIT] : power_on_q;
  assign thr_sel_d  = wr_ctl ? w_byte_q[CTL_THR_MSB:CTL_THR_LSB] : thr_sel_q;

  // Only a written 0 clears the request flag; an event in the same cycle wins.
  assign sw_clear_irq = wr_ctl && !w_byte_q[CTL_IRQ_BIT];
  assign irq_flag_d   = monitor_event || (irq_flag_q && !sw_clear_irq);

  assign irq_enable_d = wr_ie2 ? w_byte_q[IE2_MONITOR_BIT] : irq_enable_q;
  assign irq_prio_d   = wr_ip2 ? w_byte_q[IP2_MONITOR_BIT] : irq_prio_q;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      power_on_q   <= CTL_RESET[CTL_POWER_BIT];
      thr_sel_q    <= CTL_RESET[CTL_THR_MSB:CTL_THR_LSB];
      below_q      <= CTL_RESET[CTL_BELOW_BIT];
      irq_flag_q   <= CTL_RESET[CTL_IRQ_BIT];
      irq_enable_q <= IE2_RESET[IE2_MONITOR_BIT];
      irq_prio_q   <= IP2_RESET[IP2_MONITOR_BIT];
    end else begin
      power_on_q   <= power_on_d;
      thr_sel_q    <= thr_sel_d;
      below_q      <= below_d;
      irq_flag_q   <= irq_flag_d;
      irq_enable_q <= irq_enable_d;
      irq_prio_q   <= irq_prio_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event status and mask for the bus interrupt.

  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic       evt_irq;
  logic [1:0] evt_set;

  assign evt_set[EVT_FALL_BIT] = fall_event;
  assign evt_set[EVT_RISE_BIT] = rise_event;

  lvm_event_bank u_events (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .event_set (evt_set),
    .status_wr (wr_lane && hit_w_evs),
    .mask_wr   (wr_lane && hit_w_evm),
    .wr_data   (w_byte_q[1:0]),
    .status_q  (evt_status),
    .mask_q    (evt_mask),
    .irq_q     (evt_irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic                ar_ready_q;
  logic                ar_ready_d;
  logic                rvalid_q;
  logic                rvalid_d;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;
  logic [1:0]          rresp_q;
  logic [1:0]          rresp_d;
  logic                ar_take;
  logic                hit_r_ie2;
  logic                hit_r_ctl;
  logic                hit_r_ip2;
  logic                hit_r_evs;
  logic                hit_r_evm;
  logic                hit_r_any;
  logic [7:0]          ctl_view;
  logic [7:0]          ie2_view;
  logic [7:0]          ip2_view;
  logic [7:0]          rd_byte;

  assign ar_take = ARVALID && ar_ready_q;

  assign hit_r_ie2 = reg_hit(ARADDR, IDX_IRQ_ENABLE_TWO);
  assign hit_r_ctl = reg_hit(ARADDR, IDX_MONITOR_CONTROL);
  assign hit_r_ip2 = reg_hit(ARADDR, IDX_IRQ_PRIORITY_TWO);
  assign hit_r_evs = reg_hit(ARADDR, IDX_EVENT_STATUS);
  assign hit_r_evm = reg_hit(ARADDR, IDX_EVENT_MASK);
  assign hit_r_any = hit_r_ie2 || hit_r_ctl || hit_r_ip2 || hit_r_evs || hit_r_evm;

  // The status flag reads the hardware copy; writes never reach it.
  assign ctl_view = {below_q, irq_flag_q, 2'h0, thr_sel_q, power_on_q};
  assign ie2_view = {irq_enable_q, 7'h00};
  assign ip2_view = {irq_prio_q, 7'h00};

  assign rd_byte = hit_r_ctl ? ctl_view :
                   hit_r_ie2 ? ie2_view :
                   hit_r_ip2 ? ip2_view :
                   hit_r_evs ? {6'h00, evt_status} :
                   hit_r_evm ? {6'h00, evt_mask} : 8'h00;

  // ARREADY stays low while a response is held, so a second read waits for the first.
  assign rdata_d    = ar_take ? {24'h000000, rd_byte} : rdata_q;
  assign rresp_d    = ar_take ? (hit_r_any ? RESP_OKAY : RESP_SLVERR) : rresp_q;
  assign rvalid_d   = ar_take || (rvalid_q && !RREADY);
  assign ar_ready_d = !rvalid_d;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ar_ready_q <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
    end else begin
      ar_ready_q <= ar_ready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output flops toward the comparator and the interrupt controller.

  logic                out_power_q;
  logic [2:0]          out_sel_q;
  logic [MV_W-1:0]     out_mv_q;
  logic                out_req_q;
  logic                out_prio_q;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      out_power_q <= 1'b0;
      out_sel_q   <= 3'h0;
      out_mv_q    <= THR_MV_0;
      out_req_q   <= 1'b0;
      out_prio_q  <= 1'b0;
    end else begin
      out_power_q <= power_on_d;
      out_sel_q   <= thr_sel_d;
      out_mv_q    <= thr_mv(thr_sel_d);
      out_req_q   <= irq_flag_d && irq_enable_d;
      out_prio_q  <= irq_prio_d;
    end
  end

  // Every output below is a flop here or a flop inside the event bank.
  assign AWREADY              = aw_ready_q;
  assign WREADY               = w_ready_q;
  assign BVALID               = bvalid_q;
  assign BRESP                = bresp_q;
  assign ARREADY              = ar_ready_q;
  assign RVALID               = rvalid_q;
  assign RDATA                = rdata_q;
  assign RRESP                = rresp_q;
  assign MONITOR_POWER_ON     = out_power_q;
  assign THRESHOLD_SELECT     = out_sel_q;
  assign THRESHOLD_VOLTAGE_MV = out_mv_q;
  assign MONITOR_IRQ_REQ      = out_req_q;
  assign MONITOR_IRQ_PRIORITY = out_prio_q;
  assign EVENT_IRQ            = evt_irq;
endmodule

// File: inc/lvm_pkg.sv
package lvm_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned MV_W   = 13;

  // Register indexes; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE_TWO   = 10'h0aa;
  localparam logic [IDX_W-1:0] IDX_MONITOR_CONTROL  = 10'h0b7;
  localparam logic [IDX_W-1:0] IDX_IRQ_PRIORITY_TWO = 10'h0ba;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS     = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK       = 10'h0c1;

  // Field positions.
  localparam int unsigned CTL_BELOW_BIT   = 7;
  localparam int unsigned CTL_IRQ_BIT     = 6;
  localparam int unsigned CTL_THR_MSB     = 3;
  localparam int unsigned CTL_THR_LSB     = 1;
  localparam int unsigned CTL_POWER_BIT   = 0;
  localparam int unsigned IE2_MONITOR_BIT = 7;
  localparam int unsigned IP2_MONITOR_BIT = 7;
  localparam int unsigned EVT_FALL_BIT    = 0;
  localparam int unsigned EVT_RISE_BIT    = 1;

  // Reset values.
  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [7:0] IE2_RESET      = 8'h00;
  localparam logic [7:0] IP2_RESET      = 8'h00;
  localparam logic [1:0] EVT_MASK_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Threshold in millivolts for each select code.
  localparam logic [MV_W-1:0] THR_MV_0 = 13'h073a;
  localparam logic [MV_W-1:0] THR_MV_1 = 13'h0802;
  localparam logic [MV_W-1:0] THR_MV_2 = 13'h08ca;
  localparam logic [MV_W-1:0] THR_MV_3 = 13'h0992;
  localparam logic [MV_W-1:0] THR_MV_4 = 13'h0b22;
  localparam logic [MV_W-1:0] THR_MV_5 = 13'h0d7a;
  localparam logic [MV_W-1:0] THR_MV_6 = 13'h0f0a;
  localparam logic [MV_W-1:0] THR_MV_7 = 13'h1162;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0]  idx);
    reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [MV_W-1:0] thr_mv(input logic [2:0] sel);
    case (sel)
      3'h0:    thr_mv = THR_MV_0;
      3'h1:    thr_mv = THR_MV_1;
      3'h2:    thr_mv = THR_MV_2;
      3'h3:    thr_mv = THR_MV_3;
      3'h4:    thr_mv = THR_MV_4;
      3'h5:    thr_mv = THR_MV_5;
      3'h6:    thr_mv = THR_MV_6;
      default: thr_mv = THR_MV_7;
    endcase
  endfunction

endpackage

// File: hw/lvm_sync2.sv
`timescale 1ns/1ps
module lvm_sync2 (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: hw/lvm_event_bank.sv
`timescale 1ns/1ps
module lvm_event_bank (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Event pulses.
  input  wire logic [1:0] event_set,
  // Software access.
  input  wire logic       status_wr,
  input  wire logic       mask_wr,
  input  wire logic [1:0] wr_data,
  // State and interrupt.
  output logic      [1:0] status_q,
  output logic      [1:0] mask_q,
  output logic            irq_q
);
  import lvm_pkg::*;

  logic [1:0] status_d;
  logic [1:0] mask_d;

  // Writing a one clears a bit; a new event in the same cycle wins.
  assign status_d = (status_q & ~(status_wr ? wr_data : 2'h0)) | event_set;
  assign mask_d   = mask_wr ? wr_data : mask_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= 2'h0;
      mask_q   <= EVT_MASK_RESET;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= |(status_d & mask_d);
    end
  end
endmodule

// File: test/lvm_monitor_assertions.sv
`timescale 1ns/1ps
module lvm_monitor_assertions (
  // Clock and reset.
  input wire logic                       CORE_CLK,
  input wire logic                       RESET,
  // Bus handshakes.
  input wire logic                       AWVALID,
  input wire logic                       AWREADY,
  input wire logic                       WVALID,
  input wire logic                       WREADY,
  input wire logic                       BVALID,
  input wire logic                       ARVALID,
  input wire logic                       ARREADY,
  input wire logic                       RVALID,
  input wire logic [lvm_pkg::DATA_W-1:0] RDATA,
  // Monitor outputs.
  input wire logic                       MONITOR_POWER_ON,
  input wire logic [2:0]                 THRESHOLD_SELECT,
  input wire logic [lvm_pkg::MV_W-1:0]   THRESHOLD_VOLTAGE_MV,
  input wire logic                       MONITOR_IRQ_REQ,
  input wire logic                       MONITOR_IRQ_PRIORITY,
  input wire logic                       EVENT_IRQ
);
  import lvm_pkg::*;
  localparam logic [MV_W-1:0] MV_TAB [8] = '{13'h073a, 13'h0802, 13'h08ca, 13'h0992,
                                            13'h0b22, 13'h0d7a, 13'h0f0a, 13'h1162};
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////
  sequence wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_take;
    ARVALID && ARREADY;
  endsequence
  thr_table_a: assert property (THRESHOLD_VOLTAGE_MV == MV_TAB[THRESHOLD_SELECT])
    else $error("threshold millivolts do not match select code");
  prio_hold_a: assert property (!$rose(BVALID) |-> $stable(MONITOR_IRQ_PRIORITY))
    else $error("priority changed without a write");
  ctl_hold_a: assert property (!$rose(BVALID) |->
    $stable({MONITOR_POWER_ON, THRESHOLD_SELECT}))
    else $error("power or select changed without a write");
  req_clear_a: assert property ($fell(MONITOR_IRQ_REQ) |-> $rose(BVALID))
    else $error("request dropped without a write");
  evt_clear_a: assert property ($fell(EVENT_IRQ) |-> $rose(BVALID))
    else $error("event interrupt dropped without a write");
  off_quiet_a: assert property (($rose(MONITOR_IRQ_REQ) || $rose(EVENT_IRQ)) && !$rose(BVALID)
    |-> $past(MONITOR_POWER_ON))
    else $error("event raised while monitor powered off");
  wr_resp_a: assert property (wr_take |-> ##2 BVALID)
    else $error("write response late");
  rd_resp_a: assert property (rd_take |=> RVALID && RDATA[31:8] == 24'h0)
    else $error("read response late or upper bits set");
endmodule

bind lvm_monitor lvm_monitor_assertions u_chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RDATA(RDATA), .MONITOR_POWER_ON(MONITOR_POWER_ON),
  .THRESHOLD_SELECT(THRESHOLD_SELECT), .THRESHOLD_VOLTAGE_MV(THRESHOLD_VOLTAGE_MV),
  .MONITOR_IRQ_REQ(MONITOR_IRQ_REQ), .MONITOR_IRQ_PRIORITY(MONITOR_IRQ_PRIORITY),
  .EVENT_IRQ(EVENT_IRQ)
);

// File: test/lvm_supply_model.sv
`timescale 1ns/1ps
module lvm_supply_model (
  // Clock.
  input wire logic        clk,
  // Control from the block.
  input wire logic        power_on,
  input wire logic [12:0] thr_mv,
  // Supply level and comparator result.
  input wire logic [12:0] supply_mv,
  output logic            below
);
  logic junk_q;
  // An unpowered comparator gives no valid result, so it toggles.
  always @(posedge clk) begin
    junk_q <= ~junk_q;
  end
  initial junk_q = 1'b0;
  assign below = power_on ? (supply_mv < thr_mv) : junk_q;
endmodule

// File: test/lvm_monitor_tb.sv
`timescale 1ns/1ps
module lvm_monitor_tb;
  import lvm_pkg::*;
  typedef struct packed { logic [2:0] code; logic [MV_W-1:0] mv; } lvm_row_t;
  localparam lvm_row_t ROWS [8] = '{'{3'h0, 13'h073a}, '{3'h1, 13'h0802}, '{3'h2, 13'h08ca},
    '{3'h3, 13'h0992}, '{3'h4, 13'h0b22}, '{3'h5, 13'h0d7a}, '{3'h6, 13'h0f0a}, '{3'h7, 13'h1162}};
  localparam logic [IDX_W-1:0] IDX_NONE = 10'h040;
  logic              CORE_CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  logic              AWREADY, WREADY, BVALID, ARREADY, RVALID, SUPPLY_BELOW;
  logic [1:0]        BRESP, RRESP;
  logic              MONITOR_POWER_ON, MONITOR_IRQ_REQ, MONITOR_IRQ_PRIORITY, EVENT_IRQ;
  logic [2:0]        THRESHOLD_SELECT;
  logic [MV_W-1:0]   THRESHOLD_VOLTAGE_MV, supply_mv;
  int                error_cnt, comparisons, cyc;

  lvm_monitor uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .AWADDR(AWADDR), .AWPROT(3'h0),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .SUPPLY_BELOW(SUPPLY_BELOW),
    .MONITOR_POWER_ON(MONITOR_POWER_ON), .THRESHOLD_SELECT(THRESHOLD_SELECT),
    .THRESHOLD_VOLTAGE_MV(THRESHOLD_VOLTAGE_MV), .MONITOR_IRQ_REQ(MONITOR_IRQ_REQ),
    .MONITOR_IRQ_PRIORITY(MONITOR_IRQ_PRIORITY), .EVENT_IRQ(EVENT_IRQ));
  lvm_supply_model u_sup (.clk(CORE_CLK), .power_on(MONITOR_POWER_ON),
    .thr_mv(THRESHOLD_VOLTAGE_MV), .supply_mv(supply_mv), .below(SUPPLY_BELOW));

  initial CORE_CLK = 1'b0;
  always #2.5 CORE_CLK = ~CORE_CLK;
  ////////////////////////////////////////
  task automatic test_done;
    $display("TB: %0d comparisons, %0d errors", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus tasks start just after a rising edge and return just after the answering edge.
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    AWADDR <= {idx, 2'h0};
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (a || w) begin
      @(posedge CORE_CLK);
      if (a && AWREADY === 1'b1) begin
        a = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    while (BVALID !== 1'b1) @(posedge CORE_CLK);
    chk(32'(BRESP), 32'(er));
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e, input logic [1:0] er);
    ARADDR <= {idx, 2'h0};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    @(posedge CORE_CLK);
    while (ARREADY !== 1'b1) @(posedge CORE_CLK);
    ARVALID <= 1'b0;
    @(posedge CORE_CLK);
    while (RVALID !== 1'b1) @(posedge CORE_CLK);
    chk(RDATA, {24'h0, e});
    chk(32'(RRESP), 32'(er));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  ////////////////////////////////////////
  initial begin
    {RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
    AWADDR = '0;
    ARADDR = '0;
    WDATA = '0;
    supply_mv = 13'h0bb8;
    idle(16);
    chk(32'(THRESHOLD_VOLTAGE_MV), 32'h073a);
    RESET <= 1'b0;
    idle(1);
    foreach (ROWS[i]) rd(i % 3 == 0 ? IDX_IRQ_ENABLE_TWO : i % 3 == 1 ? IDX_MONITOR_CONTROL :
      IDX_IRQ_PRIORITY_TWO, 8'h00, RESP_OKAY);
    rd(IDX_EVENT_MASK, 8'h00, RESP_OKAY);
    rd(IDX_NONE, 8'h00, RESP_SLVERR);
    wr(IDX_NONE, 8'hff, RESP_SLVERR);
    $display("TB: reset test done");
    foreach (ROWS[i]) begin
      wr(IDX_MONITOR_CONTROL, {4'h0, ROWS[i].code, 1'b0}, RESP_OKAY);
      rd(IDX_MONITOR_CONTROL, {4'h0, ROWS[i].code, 1'b0}, RESP_OKAY);
      chk(32'(THRESHOLD_VOLTAGE_MV), 32'(ROWS[i].mv));
      chk(32'(THRESHOLD_SELECT), 32'(ROWS[i].code));
    end
    $display("TB: threshold test done");
    wr(IDX_IRQ_ENABLE_TWO, 8'hff, RESP_OKAY);
    rd(IDX_IRQ_ENABLE_TWO, 8'h80, RESP_OKAY);
    wr(IDX_IRQ_PRIORITY_TWO, 8'hff, RESP_OKAY);
    rd(IDX_IRQ_PRIORITY_TWO, 8'h80, RESP_OKAY);
    chk(32'(MONITOR_IRQ_PRIORITY), 32'h1);
    wr(IDX_EVENT_MASK, 8'h03, RESP_OKAY);
    wr(IDX_MONITOR_CONTROL, 8'h09, RESP_OKAY);
    idle(8);
    rd(IDX_MONITOR_CONTROL, 8'h09, RESP_OKAY);
    chk(32'(MONITOR_POWER_ON), 32'h1);
    supply_mv <= 13'h09c4;
    idle(8);
    chk(32'(MONITOR_IRQ_REQ), 32'h1);
    chk(32'(EVENT_IRQ), 32'h1);
    rd(IDX_MONITOR_CONTROL, 8'hc9, RESP_OKAY);
    rd(IDX_EVENT_STATUS, 8'h01, RESP_OKAY);
    wr(IDX_MONITOR_CONTROL, 8'h49, RESP_OKAY);
    rd(IDX_MONITOR_CONTROL, 8'hc9, RESP_OKAY);
    wr(IDX_MONITOR_CONTROL, 8'h09, RESP_OKAY);
    rd(IDX_MONITOR_CONTROL, 8'h89, RESP_OKAY);
    chk(32'(MONITOR_IRQ_REQ), 32'h0);
    wr(IDX_EVENT_STATUS, 8'h01, RESP_OKAY);
    chk(32'(EVENT_IRQ), 32'h0);
    supply_mv <= 13'h0bb8;
    idle(8);
    rd(IDX_MONITOR_CONTROL, 8'h49, RESP_OKAY);
    rd(IDX_EVENT_STATUS, 8'h02, RESP_OKAY);
    $display("TB: event test done");
    wr(IDX_EVENT_STATUS, 8'h03, RESP_OKAY);
    wr(IDX_MONITOR_CONTROL, 8'h08, RESP_OKAY);
    chk(32'(MONITOR_POWER_ON), 32'h0);
    supply_mv <= 13'h09c4;
    idle(8);
    rd(IDX_MONITOR_CONTROL, 8'h08, RESP_OKAY);
    chk(32'(EVENT_IRQ), 32'h0);
    wr(IDX_IRQ_ENABLE_TWO, 8'h00, RESP_OKAY);
    wr(IDX_MONITOR_CONTROL, 8'h09, RESP_OKAY);
    idle(8);
    rd(IDX_MONITOR_CONTROL, 8'hc9, RESP_OKAY);
    chk(32'(MONITOR_IRQ_REQ), 32'h0);
    wr(IDX_IRQ_ENABLE_TWO, 8'h80, RESP_OKAY);
    chk(32'(MONITOR_IRQ_REQ), 32'h1);
    $display("TB: power test done");
    RESET <= 1'b1;
    idle(2);
    chk(32'(MONITOR_IRQ_REQ), 32'h0);
    chk(32'(THRESHOLD_VOLTAGE_MV), 32'h073a);
    RESET <= 1'b0;
    idle(1);
    rd(IDX_MONITOR_CONTROL, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_PRIORITY_TWO, 8'h00, RESP_OKAY);
    $display("TB: second reset test done");
    test_done;
  end
endmodule
